// [twm_master_tx.sv]
// Purpose: Two-wire bus master transmitter with control, data and status registers
// Assumes: Open-drain pins resolved outside; pull-ups keep idle lines high
// Notes:   Bit rate fixed by the half-period constant, no prescaler
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - Start request with enable and flag clear waits for a free bus, then STARTs
// - After START the flag rises with status 0x08
// - Address write bit selects transmitter mode, read bit selects receiver mode
// - After write address: flag with 0x18 ack, 0x20 nack, 0x38 lost
// - Data byte acknowledged gives flag with status 0x28
// - Data byte not acknowledged gives flag with status 0x30
// - Data write while flag low is dropped and sets write collision
// - Writing one to flag clears it; no start/stop sends the loaded address
// - Clearing flag without start/stop sends the loaded data byte, samples ack
// - Clear with stop only sends STOP; hardware clears stop request
// - Clear with start and stop sends STOP then START, clears stop request
// - Clear with start only sends repeated START; flag with status 0x10
// - After 0x10 either address direction may follow; read enters receiver mode
// - After 0x38 clear releases bus; with start, START once bus frees
// - Clock line held low while the flag is set and the unit stays enabled
// - All bus activity suspended while flag is set
module twm_master_tx (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Register port
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Serial bus, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Mode hand-off
    output logic rx_mode_o
);
    twm_pkg::twm_state_type state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bitn_q, bitn_d;
    logic [7:0] data_q, data_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] rdata_q, rdata_d;
    logic flag_q, flag_d, acken_q, acken_d, sta_q, sta_d, sto_q, sto_d;
    logic wcol_q, wcol_d, en_q, en_d, irqen_q, irqen_d;
    logic scl_low_q, scl_low_d, sda_low_q, sda_low_d;
    logic owned_q, owned_d, first_q, first_d, rw_q, rw_d, rep_q, rep_d;
    logic rx_q, rx_d, busy_q, busy_d, scl_p_q, sda_p_q;
    logic scl_s, sda_s, wr_ctrl, clr_flag;

    // Pins pass two flops before any logic looks at them
    twm_sync #(.W(2)) u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .async_i({scl_i, sda_i}),
        .sync_o({scl_s, sda_s})
    );

    function automatic logic half_done(input logic [7:0] c);
        half_done = (c == twm_pkg::HALF_LAST);
    endfunction : half_done

    function automatic logic [7:0] ack_code(input logic first, input logic rw,
                                            input logic ack);
        if (first && !rw) begin
            ack_code = ack ? twm_pkg::SC_AW_ACK : twm_pkg::SC_AW_NACK;
        end else if (first) begin
            ack_code = ack ? twm_pkg::SC_AR_ACK : twm_pkg::SC_AR_NACK;
        end else begin
            ack_code = ack ? twm_pkg::SC_D_ACK : twm_pkg::SC_D_NACK;
        end
    endfunction : ack_code

    assign wr_ctrl = wr_i && (addr_i == twm_pkg::ADDR_CTRL);
    assign clr_flag = wr_ctrl && wdata_i[twm_pkg::CTRL_FLAG];

    // Register file, bus watcher and bit sequencer next values
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 8'h01;
        shift_d = shift_q;
        bitn_d = bitn_q;
        data_d = data_q;
        stat_d = stat_q;
        rdata_d = 8'h00;
        flag_d = flag_q;
        acken_d = acken_q;
        sta_d = sta_q;
        sto_d = sto_q;
        wcol_d = wcol_q;
        en_d = en_q;
        irqen_d = irqen_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        owned_d = owned_q;
        first_d = first_q;
        rw_d = rw_q;
        rep_d = rep_q;
        rx_d = rx_q;
        busy_d = busy_q;
        // START and STOP seen on the lines mark the bus busy or free
        if (scl_s && scl_p_q && sda_p_q && !sda_s) begin
            busy_d = 1'b1;
        end else if (scl_s && scl_p_q && !sda_p_q && sda_s) begin
            busy_d = 1'b0;
        end
        // Register reads, answered next cycle
        if (rd_i) begin
            if (addr_i == twm_pkg::ADDR_CTRL) begin
                rdata_d = {flag_q, acken_q, sta_q, sto_q, wcol_q, en_q, 1'b0, irqen_q};
            end else if (addr_i == twm_pkg::ADDR_DATA) begin
                rdata_d = data_q;
            end else if (addr_i == twm_pkg::ADDR_STAT) begin
                rdata_d = stat_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
        // Data register only accepts writes while the flag is up
        if (wr_i && addr_i == twm_pkg::ADDR_DATA) begin
            if (flag_q) begin
                data_d = wdata_i;
                wcol_d = 1'b0;
            end else begin
                wcol_d = 1'b1;
            end
        end
        if (wr_ctrl) begin
            acken_d = wdata_i[twm_pkg::CTRL_ACKEN];
            sta_d = wdata_i[twm_pkg::CTRL_STA];
            sto_d = wdata_i[twm_pkg::CTRL_STO];
            en_d = wdata_i[twm_pkg::CTRL_EN];
            irqen_d = wdata_i[twm_pkg::CTRL_IRQEN];
        end
        if (clr_flag) begin
            flag_d = 1'b0;
        end
        // Sequencer
        case (state_q)
            twm_pkg::S_IDLE: begin
                scl_low_d = 1'b0;
                sda_low_d = 1'b0;
                cnt_d = 8'h00;
                if (en_q && sta_q && !flag_q) begin
                    state_d = twm_pkg::S_WAIT_FREE;
                end
            end
            twm_pkg::S_WAIT_FREE: begin
                // A free bus must stay idle for half a bit before we claim it
                if (busy_q || !scl_s || !sda_s) begin
                    cnt_d = 8'h00;
                end else if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_START_A;
                    sda_low_d = 1'b1;
                    owned_d = 1'b1;
                    cnt_d = 8'h00;
                end
            end
            twm_pkg::S_START_A: begin
                if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_START_B;
                    scl_low_d = 1'b1;
                    cnt_d = 8'h00;
                end
            end
            twm_pkg::S_START_B: begin
                if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_HOLD;
                    flag_d = 1'b1;
                    stat_d = rep_q ? twm_pkg::SC_RSTART : twm_pkg::SC_START;
                    rep_d = 1'b0;
                    first_d = 1'b1;
                end
            end
            twm_pkg::S_HOLD: begin
                scl_low_d = 1'b1;
                cnt_d = 8'h00;
                // Nothing moves until software writes the flag clear
                if (clr_flag) begin
                    if (!wdata_i[twm_pkg::CTRL_EN]) begin
                        state_d = twm_pkg::S_IDLE;
                        owned_d = 1'b0;
                    end else if (wdata_i[twm_pkg::CTRL_STO]) begin
                        state_d = twm_pkg::S_STOP_A;
                        sda_low_d = 1'b1;
                    end else if (wdata_i[twm_pkg::CTRL_STA]) begin
                        state_d = twm_pkg::S_RS_A;
                        sda_low_d = 1'b0;
                    end else begin
                        state_d = twm_pkg::S_BIT_LO;
                        shift_d = data_q;
                        bitn_d = 4'h0;
                        if (first_q) begin
                            rw_d = data_q[0];
                        end
                    end
                end
            end
            twm_pkg::S_LOST: begin
                // Clock stays stretched until software answers, data line is let go
                scl_low_d = 1'b1;
                sda_low_d = 1'b0;
                cnt_d = 8'h00;
                if (clr_flag) begin
                    scl_low_d = 1'b0;
                    state_d = wdata_i[twm_pkg::CTRL_STA] && wdata_i[twm_pkg::CTRL_EN]
                              ? twm_pkg::S_WAIT_FREE : twm_pkg::S_IDLE;
                end
            end
            twm_pkg::S_BIT_LO: begin
                scl_low_d = 1'b1;
                sda_low_d = (bitn_q < twm_pkg::ACK_SLOT) ? !shift_q[7] : 1'b0;
                if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_BIT_HI;
                    scl_low_d = 1'b0;
                    cnt_d = 8'h00;
                end
            end
            twm_pkg::S_BIT_HI: begin
                // A slave stretching the clock holds the count at zero
                if (!scl_s) begin
                    cnt_d = 8'h00;
                end else if (half_done(cnt_q)) begin
                    cnt_d = 8'h00;
                    if (bitn_q == twm_pkg::ACK_SLOT) begin
                        state_d = twm_pkg::S_HOLD;
                        scl_low_d = 1'b1;
                        flag_d = 1'b1;
                        stat_d = ack_code(first_q, rw_q, !sda_s);
                        rx_d = first_q && rw_q;
                        first_d = 1'b0;
                    end else if (!sda_low_q && !sda_s) begin
                        // Another master pulled a one low: step off the bus
                        state_d = twm_pkg::S_LOST;
                        scl_low_d = 1'b1;
                        flag_d = 1'b1;
                        stat_d = twm_pkg::SC_ARB_LOST;
                        owned_d = 1'b0;
                    end else begin
                        state_d = twm_pkg::S_BIT_LO;
                        scl_low_d = 1'b1;
                        shift_d = {shift_q[6:0], 1'b0};
                        bitn_d = bitn_q + 4'h1;
                    end
                end
            end
            twm_pkg::S_STOP_A: begin
                if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_STOP_B;
                    scl_low_d = 1'b0;
                    cnt_d = 8'h00;
                end
            end
            twm_pkg::S_STOP_B: begin
                if (!scl_s) begin
                    cnt_d = 8'h00;
                end else if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_STOP_C;
                    sda_low_d = 1'b0;
                    cnt_d = 8'h00;
                end
            end
            twm_pkg::S_STOP_C: begin
                if (half_done(cnt_q)) begin
                    // A pending start request relaunches from idle
                    state_d = twm_pkg::S_IDLE;
                    sto_d = 1'b0;
                    owned_d = 1'b0;
                    rx_d = 1'b0;
                end
            end
            twm_pkg::S_RS_A: begin
                if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_RS_B;
                    scl_low_d = 1'b0;
                    cnt_d = 8'h00;
                end
            end
            twm_pkg::S_RS_B: begin
                if (!scl_s) begin
                    cnt_d = 8'h00;
                end else if (half_done(cnt_q)) begin
                    state_d = twm_pkg::S_START_A;
                    sda_low_d = 1'b1;
                    rep_d = 1'b1;
                    rx_d = 1'b0;
                    cnt_d = 8'h00;
                end
            end
            default: begin
                state_d = twm_pkg::S_IDLE;
            end
        endcase
        // Disabling the unit drops the bus at once
        if (wr_ctrl && !wdata_i[twm_pkg::CTRL_EN]) begin
            state_d = twm_pkg::S_IDLE;
            scl_low_d = 1'b0;
            sda_low_d = 1'b0;
            owned_d = 1'b0;
            rx_d = 1'b0;
        end
    end

    // Register stage
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= twm_pkg::S_IDLE;
            cnt_q <= 8'h00;
            shift_q <= 8'h00;
            bitn_q <= 4'h0;
            data_q <= twm_pkg::DATA_RST;
            stat_q <= twm_pkg::STAT_RST;
            rdata_q <= 8'h00;
            flag_q <= 1'b0;
            acken_q <= 1'b0;
            sta_q <= 1'b0;
            sto_q <= 1'b0;
            wcol_q <= 1'b0;
            en_q <= 1'b0;
            irqen_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            owned_q <= 1'b0;
            first_q <= 1'b0;
            rw_q <= 1'b0;
            rep_q <= 1'b0;
            rx_q <= 1'b0;
            busy_q <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            bitn_q <= bitn_d;
            data_q <= data_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
            flag_q <= flag_d;
            acken_q <= acken_d;
            sta_q <= sta_d;
            sto_q <= sto_d;
            wcol_q <= wcol_d;
            en_q <= en_d;
            irqen_q <= irqen_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            owned_q <= owned_d;
            first_q <= first_d;
            rw_q <= rw_d;
            rep_q <= rep_d;
            rx_q <= rx_d;
            busy_q <= busy_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_low_q;
    assign sda_oe_o = sda_low_q;
    assign rdata_o = rdata_q;
    assign rx_mode_o = rx_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    property p_start_req;
        state_q == twm_pkg::S_IDLE && wr_ctrl && wdata_i == 8'ha4 |=> ##1
            state_q == twm_pkg::S_WAIT_FREE;
    endproperty
    a_start_req: assert property (p_start_req) else $error("start request ignored");
    property p_start_code;
        $rose(flag_q) && $past(state_q) == twm_pkg::S_START_B && !$past(rep_q) |->
            stat_q == twm_pkg::SC_START;
    endproperty
    a_start_code: assert property (p_start_code) else $error("bad START status");
    property p_addr_ack;
        $rose(flag_q) && $past(state_q) == twm_pkg::S_BIT_HI && $past(first_q)
            && $past(bitn_q) == twm_pkg::ACK_SLOT
            && !$past(rw_q) && !$past(sda_s) |-> stat_q == twm_pkg::SC_AW_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("bad address ack status");
    property p_wcol;
        wr_i && addr_i == twm_pkg::ADDR_DATA && !flag_q |=> wcol_q && $stable(data_q);
    endproperty
    a_wcol: assert property (p_wcol) else $error("collision not flagged");
    property p_send;
        state_q == twm_pkg::S_HOLD && clr_flag && (wdata_i & 8'h34) == 8'h04 |=>
            state_q == twm_pkg::S_BIT_LO && !flag_q && shift_q == $past(data_q)
            ##1 sda_oe_o == !shift_q[7];
    endproperty
    a_send: assert property (p_send) else $error("byte not launched");
    property p_stop;
        state_q == twm_pkg::S_HOLD && clr_flag && (wdata_i & 8'h34) == 8'h14 |=>
            sto_q ##[1:300] !sto_q && !owned_q;
    endproperty
    a_stop: assert property (p_stop) else $error("STOP not finished");
    property p_rstart;
        state_q == twm_pkg::S_HOLD && clr_flag && (wdata_i & 8'h34) == 8'h24 |=>
            state_q == twm_pkg::S_RS_A ##[1:300] flag_q && stat_q == twm_pkg::SC_RSTART;
    endproperty
    a_rstart: assert property (p_rstart) else $error("repeated START failed");
    property p_hold_scl;
        flag_q && (state_q == twm_pkg::S_HOLD || state_q == twm_pkg::S_LOST) ##1 flag_q
            |-> scl_oe_o;
    endproperty
    a_hold_scl: assert property (p_hold_scl) else $error("clock released while flagged");
    property p_suspend;
        flag_q ##1 flag_q |-> $stable(sda_oe_o) && $stable(bitn_q);
    endproperty
    a_suspend: assert property (p_suspend) else $error("bus moved while flagged");
    property p_stat_sync;
        !$stable(stat_q) |-> $rose(flag_q);
    endproperty
    a_stat_sync: assert property (p_stat_sync) else $error("status changed off flag");
endmodule : twm_master_tx

// [twm_pkg.sv]
// Purpose: Shared constants and state codes for the two-wire master transmitter
// Assumes: 250 MHz system clock, 8-bit register file on a plain strobe port
// Notes:   Status codes are given with the low three bits already zero
package twm_pkg;
    // Register offsets
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_STAT = 2'h2;

    // Bit positions in bus_control
    localparam int CTRL_FLAG = 7;
    localparam int CTRL_ACKEN = 6;
    localparam int CTRL_STA = 5;
    localparam int CTRL_STO = 4;
    localparam int CTRL_WCOL = 3;
    localparam int CTRL_EN = 2;
    localparam int CTRL_IRQEN = 0;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] STAT_RST = 8'hf8;

    // Status codes
    localparam logic [7:0] SC_START = 8'h08;
    localparam logic [7:0] SC_RSTART = 8'h10;
    localparam logic [7:0] SC_AW_ACK = 8'h18;
    localparam logic [7:0] SC_AW_NACK = 8'h20;
    localparam logic [7:0] SC_D_ACK = 8'h28;
    localparam logic [7:0] SC_D_NACK = 8'h30;
    localparam logic [7:0] SC_ARB_LOST = 8'h38;
    localparam logic [7:0] SC_AR_ACK = 8'h40;
    localparam logic [7:0] SC_AR_NACK = 8'h48;

    // Timing: half of one bus bit period
    localparam int CLK_NS = 4;
    localparam int T_HALF_NS = 80;
    localparam int HALF_CYC = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    // Bit counter value of the acknowledge slot
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_WAIT_FREE = 4'h1,
        S_START_A = 4'h2,
        S_START_B = 4'h3,
        S_BIT_LO = 4'h4,
        S_BIT_HI = 4'h5,
        S_HOLD = 4'h6,
        S_STOP_A = 4'h7,
        S_STOP_B = 4'h8,
        S_STOP_C = 4'h9,
        S_RS_A = 4'ha,
        S_RS_B = 4'hb,
        S_LOST = 4'hc
    } twm_state_type;
endpackage : twm_pkg

// [twm_sync.sv]
// Purpose: Two-flop synchroniser for the serial bus pins
// Assumes: Inputs are asynchronous to clk_sys_i
// Notes:   Only the second stage leaves this module
`timescale 1ns/10ps
module twm_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Pins
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Idle bus lines float high, so reset to ones
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : twm_sync

// [twm_slave_model.sv]
// Purpose: Behavioural slave receiver on the two-wire bus, the far side of the master
// Assumes: Wires resolved by the bench with pull-ups; the model never stretches the clock
// Notes:   Ack or nack is chosen by the bench per byte through ack_en_i
`timescale 1ns/10ps
module twm_slave_model (
    // Bus lines as seen on the wire
    input wire logic scl_i,
    input wire logic sda_i,
    // Behaviour select
    input wire logic ack_en_i,
    // Open-drain data drive and last byte taken
    output logic sda_oe_o,
    output logic [7:0] byte_o
);
    int bit_n;
    logic [7:0] shift_q;

    // Line released at start, nothing received yet
    initial begin
        sda_oe_o = 1'b0;
        byte_o = 8'h00;
        bit_n = 0;
        shift_q = 8'h00;
    end

    // Data falling while clock high is a START or repeated START
    always @(negedge sda_i) begin
        if (scl_i) begin
            bit_n = 0;
        end
    end

    // Bits are taken on the rising clock, MSB first
    always @(posedge scl_i) begin
        if (bit_n < 8) begin
            shift_q = {shift_q[6:0], sda_i};
        end
        bit_n = bit_n + 1;
    end

    // Ack held only over the ninth clock, so the master regains the line at once
    always @(negedge scl_i) begin
        if (bit_n == 8) begin
            byte_o = shift_q;
            sda_oe_o = ack_en_i;
        end else if (bit_n == 9) begin
            sda_oe_o = 1'b0;
            bit_n = 0;
        end
    end
endmodule : twm_slave_model

// [twm_master_tx_tb.sv]
// Purpose: Self-checking bench for the two-wire master transmitter
// Assumes: Register port strobes of one cycle, read data one cycle after the strobe
// Notes:   A bench pull-down on the data line stands in for a rival master
`timescale 1ns/10ps
module twm_master_tx_tb;
    logic clk_sys_i, srst_i, wr_i, rd_i, scl_oe_o, sda_oe_o, rx_mode_o;
    logic slv_sda_oe, ack_en, tb_sda_low;
    logic [1:0] addr_i;
    logic [7:0] wdata_i, rdata_o, rd_v, slv_byte, bus_v;
    wire logic scl_w, sda_w;
    int err_count, total_checks;

    // Open-drain wires with pull-ups
    assign scl_w = ~scl_oe_o;
    assign sda_w = ~(sda_oe_o | slv_sda_oe | tb_sda_low);

    twm_master_tx i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w),
        .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o),
        .rx_mode_o(rx_mode_o));

    twm_slave_model i_slave (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en),
        .sda_oe_o(slv_sda_oe), .byte_o(slv_byte));

    // System clock, 4 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : reg_rd

    // Poll a control bit until it reaches the wanted level, bounded
    task automatic poll_ctrl(input int bit_i, input logic want);
        int n;
        n = 0;
        rd_v = {8{~want}};
        while (rd_v[bit_i] !== want && n < 3000) begin
            reg_rd(twm_pkg::ADDR_CTRL, rd_v);
            n++;
        end
        chk(8'(rd_v[bit_i]), 8'(want), "control bit wait");
    endtask : poll_ctrl

    // Control write, wait for the flag, then status and a frozen bus
    task automatic op(input logic [7:0] ctl, input logic [7:0] exp_st);
        reg_wr(twm_pkg::ADDR_CTRL, ctl);
        poll_ctrl(twm_pkg::CTRL_FLAG, 1'b1);
        reg_rd(twm_pkg::ADDR_STAT, rd_v);
        chk(rd_v & 8'hf8, exp_st, "status");
        chk(8'(scl_w), 8'h00, "clock held low");
        bus_v = {6'h00, scl_w, sda_w};
        repeat (60) @(posedge clk_sys_i);
        chk({6'h00, scl_w, sda_w}, bus_v, "bus frozen");
    endtask : op

    task automatic send(input logic [7:0] d, input logic [7:0] exp_st);
        reg_wr(twm_pkg::ADDR_DATA, d);
        op(8'h84, exp_st);
        chk(slv_byte, d, "byte on wire");
    endtask : send

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog well beyond the expected few thousand cycles
    initial begin
        #240000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // Main sequence
    initial begin
        addr_i = 2'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        ack_en = 1'b1;
        tb_sda_low = 1'b0;
        err_count = 0;
        total_checks = 0;
        srst_i = 1'b1;
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        reg_rd(twm_pkg::ADDR_CTRL, rd_v);
        chk(rd_v, 8'h00, "control reset");
        reg_rd(twm_pkg::ADDR_DATA, rd_v);
        chk(rd_v, twm_pkg::DATA_RST, "data reset");
        reg_rd(twm_pkg::ADDR_STAT, rd_v);
        chk(rd_v, twm_pkg::STAT_RST, "status reset");
        reg_rd(2'h3, rd_v);
        chk(rd_v, 8'h00, "unmapped read");
        reg_wr(twm_pkg::ADDR_DATA, 8'h55);
        reg_rd(twm_pkg::ADDR_CTRL, rd_v);
        chk(rd_v & 8'h08, 8'h08, "collision bit");
        reg_rd(twm_pkg::ADDR_DATA, rd_v);
        chk(rd_v, twm_pkg::DATA_RST, "dropped data write");
        $display("test registers done");
        op(8'ha4, twm_pkg::SC_START);
        send(8'ha6, twm_pkg::SC_AW_ACK);
        send(8'h5c, twm_pkg::SC_D_ACK);
        ack_en <= 1'b0;
        send(8'h3f, twm_pkg::SC_D_NACK);
        ack_en <= 1'b1;
        op(8'ha4, twm_pkg::SC_RSTART);
        send(8'ha7, twm_pkg::SC_AR_ACK);
        chk(8'(rx_mode_o), 8'h01, "receiver hand-off");
        reg_wr(twm_pkg::ADDR_CTRL, 8'h94);
        poll_ctrl(twm_pkg::CTRL_STO, 1'b0);
        chk({6'h00, scl_w, sda_w}, 8'h03, "bus free after stop");
        chk(8'(rx_mode_o), 8'h00, "receiver mode left");
        $display("test write transfer done");
        op(8'ha4, twm_pkg::SC_START);
        ack_en <= 1'b0;
        send(8'ha6, twm_pkg::SC_AW_NACK);
        ack_en <= 1'b1;
        op(8'hb4, twm_pkg::SC_START);
        reg_rd(twm_pkg::ADDR_CTRL, rd_v);
        chk(rd_v & 8'h10, 8'h00, "stop request cleared");
        $display("test nack and stop-start done");
        reg_wr(twm_pkg::ADDR_DATA, 8'ha6);
        tb_sda_low <= 1'b1;
        op(8'h84, twm_pkg::SC_ARB_LOST);
        tb_sda_low <= 1'b0;
        reg_wr(twm_pkg::ADDR_CTRL, 8'h84);
        repeat (100) @(posedge clk_sys_i);
        chk({6'h00, scl_oe_o, sda_oe_o}, 8'h00, "bus released");
        reg_rd(twm_pkg::ADDR_CTRL, rd_v);
        chk(rd_v & 8'h80, 8'h00, "flag cleared");
        $display("test arbitration done");
        tally_and_finish();
    end
endmodule : twm_master_tx_tb
